/* rtl/tcsp_consts.svh */
// Purpose: Constants of the Type-C standalone port signal block
// Assumes: Included by its bare name from the RTL top and the testbench top
// Notes: Offsets are byte addresses on the register bus
`ifndef TCSP_CONSTS_SVH
`define TCSP_CONSTS_SVH

// ==========================================================
// Register offsets
`define TCSP_OFS_CTRL 4'h0
`define TCSP_OFS_STATUS 4'h4
`define TCSP_OFS_IRQ_STAT 4'h8
`define TCSP_OFS_IRQ_MASK 4'hc

// ==========================================================
// Field positions and reset values
`define TCSP_CTRL_MODE_LSB 0
`define TCSP_CTRL_RST 2'h0
`define TCSP_MASK_RST 4'h0
`define TCSP_IRQ_EXT_OC 0
`define TCSP_IRQ_VCONN_OC 1
`define TCSP_IRQ_ATTACH 2
`define TCSP_IRQ_ADV 3

// ==========================================================
// Timing
`define TCSP_CLK_NS 5
`define TCSP_RECOVER_NS 100000

// ==========================================================
// Bus answers
`define TCSP_RESP_OKAY 2'h0
`define TCSP_RESP_DECERR 2'h3

`endif

/* rtl/tcsp_pkg.sv */
// Purpose: Types of the Type-C standalone port signal block
// Assumes: tcsp_consts.svh holds all numbers
// Notes: Types only
package tcsp_pkg;

    // ==========================================================
    // Operating modes
    typedef enum logic [1:0] {
        TCSP_MODE_OFF = 2'h0,
        TCSP_MODE_SOURCE = 2'h1,
        TCSP_MODE_SINK = 2'h2,
        TCSP_MODE_RSVD = 2'h3
    } tcsp_mode_type;

    // Advertised source current seen on CC
    typedef enum logic [1:0] {
        TCSP_ADV_NONE = 2'h0,
        TCSP_ADV_DEFAULT = 2'h1,
        TCSP_ADV_1A5 = 2'h2,
        TCSP_ADV_3A0 = 2'h3
    } tcsp_adv_type;

    // Sink indication group, one bit per open-drain pin (1 = pulled low)
    typedef struct packed {
        logic high;
        logic mid;
        logic dflt;
    } tcsp_sink_ind_type;

    // Interrupt event vector
    typedef struct packed {
        logic adv;
        logic attach;
        logic vconn_oc;
        logic ext_oc;
    } tcsp_irq_type;

endpackage

/* rtl/tcsp_port_signals.sv */
// Purpose: Standalone source/sink pin control with AXI4-Lite registers
// Assumes: attach, advertisement and VCONN fault come from on-clock logic
// Notes: Open-drain pins are data/enable pairs; data is always low
//
// Contract
// - Source mode drives supply switch enable to power VBUS externally.
// - Enable high means VBUS on, low means VBUS off.
// - Recovery strap low: stay in fault state after overcurrent.
// - Recovery strap high: retry automatically after external or VCONN overcurrent.
// - Sink mode asserts default-current pin on legacy advertisement.
// - Sink mode asserts mid-current pin on 1.5 A advertisement.
// - Sink mode asserts high-current pin on 3.0 A advertisement.
// - Interrupt line is pulled low while an unmasked interrupt is pending.
// - No sourcing while host power grant low; source on attach when high.
// - Low overcurrent input is an overcurrent event raising its interrupt.
// - Fault report pulled low in source mode while faulted and through the recovery wait after the fault clears.
`timescale 1ns/1ps
`include "tcsp_consts.svh"
`default_nettype none

module tcsp_port_signals #(
    parameter int unsigned RECOVER_CYCLES = `TCSP_RECOVER_NS / `TCSP_CLK_NS
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    // AXI4-Lite slave
    input wire logic [3:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [3:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Port detection, same clock
    input wire logic attach_i,
    input wire tcsp_pkg::tcsp_adv_type adv_i,
    input wire logic vconn_overcurrent_i,
    // Pins, asynchronous
    input wire logic host_port_power_grant_i,
    input wire logic overcurrent_fault_in_n_i,
    input wire logic fault_recovery_sel_i,
    // Pins out
    output logic port_supply_en_o,
    output logic fault_report_out_o,
    output logic fault_report_out_oe_o,
    output tcsp_pkg::tcsp_sink_ind_type sink_ind_o,
    output tcsp_pkg::tcsp_sink_ind_type sink_ind_oe_o,
    output logic irq_n_o,
    output logic irq_n_oe_o
);
    import tcsp_pkg::*;

    // ==========================================================
    // Pin synchronisers, first stage read only by second
    logic [2:0] pin_meta_q;
    logic [2:0] pin_sync_q;
    logic grant_s, oc_n_s, recov_sel_s;

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            pin_meta_q <= 3'h2;
            pin_sync_q <= 3'h2;
        end else begin
            pin_meta_q <= {fault_recovery_sel_i, overcurrent_fault_in_n_i,
                           host_port_power_grant_i};
            pin_sync_q <= pin_meta_q;
        end
    end

    assign grant_s = pin_sync_q[0];
    assign oc_n_s = pin_sync_q[1];
    assign recov_sel_s = pin_sync_q[2];

    // ==========================================================
    // Source power state machine
    typedef enum logic [1:0] {
        SRC_IDLE,
        SRC_ON,
        SRC_FAULT,
        SRC_WAIT
    } tcsp_src_state_type;

    tcsp_src_state_type src_state_q, src_state_d;
    logic [15:0] rec_cnt_q, rec_cnt_d;
    tcsp_mode_type mode_q, mode_d;
    logic src_mode, sink_mode, ext_oc, any_oc;

    assign src_mode = (mode_q == TCSP_MODE_SOURCE);
    assign sink_mode = (mode_q == TCSP_MODE_SINK);
    assign ext_oc = !oc_n_s; // Active-low fault from external switch
    assign any_oc = ext_oc || vconn_overcurrent_i;

    // Next state; leaving source mode clears a latched fault
    always_comb begin
        src_state_d = src_state_q;
        rec_cnt_d = rec_cnt_q;
        if (!src_mode) begin
            src_state_d = SRC_IDLE;
        end else begin
            unique case (src_state_q)
                SRC_IDLE: begin
                    if (any_oc) begin
                        src_state_d = SRC_FAULT;
                    end else if (attach_i && grant_s) begin
                        src_state_d = SRC_ON;
                    end
                end
                SRC_ON: begin
                    if (any_oc) begin
                        src_state_d = SRC_FAULT;
                    end else if (!attach_i || !grant_s) begin
                        src_state_d = SRC_IDLE;
                    end
                end
                SRC_FAULT: begin
                    // Strap low holds here until mode change
                    if (recov_sel_s && !any_oc) begin
                        src_state_d = SRC_WAIT;
                        rec_cnt_d = RECOVER_CYCLES[15:0];
                    end
                end
                SRC_WAIT: begin
                    // Cool-down so a hard short does not hammer the switch
                    if (any_oc) begin
                        src_state_d = SRC_FAULT;
                    end else if (rec_cnt_q <= 16'h0001) begin
                        src_state_d = SRC_IDLE;
                    end else begin
                        rec_cnt_d = rec_cnt_q - 16'h0001;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            src_state_q <= SRC_IDLE;
            rec_cnt_q <= 16'h0000;
        end else begin
            src_state_q <= src_state_d;
            rec_cnt_q <= rec_cnt_d;
        end
    end

    // ==========================================================
    // Pin outputs, all registered
    logic supply_en_q, supply_en_d;
    logic fault_oe_q, fault_oe_d;
    tcsp_sink_ind_type sink_oe_q, sink_oe_d;
    logic irq_oe_q, irq_oe_d;
    logic od_low_q;
    tcsp_irq_type irq_stat_q, irq_stat_d;
    tcsp_irq_type irq_mask_q, irq_mask_d;

    // One-hot sink indication from the advertisement
    always_comb begin
        supply_en_d = src_mode && (src_state_d == SRC_ON);
        fault_oe_d = src_mode && (src_state_d == SRC_FAULT ||
                                  src_state_d == SRC_WAIT);
        sink_oe_d = '0;
        if (sink_mode && attach_i) begin
            unique case (adv_i)
                TCSP_ADV_DEFAULT: sink_oe_d.dflt = 1'b1;
                TCSP_ADV_1A5: sink_oe_d.mid = 1'b1;
                TCSP_ADV_3A0: sink_oe_d.high = 1'b1;
                TCSP_ADV_NONE: sink_oe_d = '0;
            endcase
        end
        irq_oe_d = |(irq_stat_d & irq_mask_q); // Pull low while pending
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            supply_en_q <= 1'b0;
            fault_oe_q <= 1'b0;
            sink_oe_q <= '0;
            irq_oe_q <= 1'b0;
            od_low_q <= 1'b0;
        end else begin
            supply_en_q <= supply_en_d;
            fault_oe_q <= fault_oe_d;
            sink_oe_q <= sink_oe_d;
            irq_oe_q <= irq_oe_d;
            od_low_q <= 1'b0;
        end
    end

    assign port_supply_en_o = supply_en_q;
    assign fault_report_out_o = od_low_q;
    assign fault_report_out_oe_o = fault_oe_q;
    assign sink_ind_o = {3{od_low_q}};
    assign sink_ind_oe_o = sink_oe_q;
    assign irq_n_o = od_low_q;
    assign irq_n_oe_o = irq_oe_q;

    // ==========================================================
    // Event edges for the interrupt status register
    logic ext_oc_q;
    logic vconn_oc_q;
    logic attach_q;
    tcsp_adv_type adv_q;
    tcsp_irq_type evt;

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            ext_oc_q <= 1'b0;
            vconn_oc_q <= 1'b0;
            attach_q <= 1'b0;
            adv_q <= TCSP_ADV_NONE;
        end else begin
            ext_oc_q <= ext_oc;
            vconn_oc_q <= vconn_overcurrent_i;
            attach_q <= attach_i;
            adv_q <= adv_i;
        end
    end

    always_comb begin
        evt.ext_oc = ext_oc && !ext_oc_q;
        evt.vconn_oc = vconn_overcurrent_i && !vconn_oc_q;
        evt.attach = attach_i != attach_q;
        evt.adv = adv_i != adv_q;
    end

    // ==========================================================
    // AXI4-Lite slave
    logic aw_full_q, aw_full_d;
    logic w_full_q, w_full_d;
    logic [3:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0] w_strb_q, w_strb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic awready_q, awready_d;
    logic wready_q, wready_d;
    logic arready_q, arready_d;
    logic do_wr;

    // Address and data taken in either order, write once both held
    always_comb begin
        aw_full_d = aw_full_q;
        w_full_d = w_full_q;
        aw_addr_d = aw_addr_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        mode_d = mode_q;
        irq_mask_d = irq_mask_q;
        irq_stat_d = irq_stat_q;
        do_wr = aw_full_q && w_full_q && !bvalid_q;
        if (s_axi_awvalid_i && awready_q) begin
            aw_full_d = 1'b1;
            aw_addr_d = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && wready_q) begin
            w_full_d = 1'b1;
            w_data_d = s_axi_wdata_i;
            w_strb_d = s_axi_wstrb_i;
        end
        if (bvalid_q && s_axi_bready_i) begin
            bvalid_d = 1'b0;
        end
        if (do_wr) begin
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = `TCSP_RESP_OKAY;
            unique case (aw_addr_q)
                `TCSP_OFS_CTRL: if (w_strb_q[0]) begin
                    mode_d = tcsp_mode_type'(w_data_q[`TCSP_CTRL_MODE_LSB +: 2]);
                end
                `TCSP_OFS_STATUS: ;
                `TCSP_OFS_IRQ_STAT: if (w_strb_q[0]) begin
                    irq_stat_d = irq_stat_q & ~tcsp_irq_type'(w_data_q[3:0]);
                end
                `TCSP_OFS_IRQ_MASK: if (w_strb_q[0]) begin
                    irq_mask_d = tcsp_irq_type'(w_data_q[3:0]);
                end
                default: bresp_d = `TCSP_RESP_DECERR;
            endcase
        end
        // New events win over a same-cycle clear
        irq_stat_d = irq_stat_d | evt;
        if (rvalid_q && s_axi_rready_i) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid_i && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d = `TCSP_RESP_OKAY;
            rdata_d = 32'h0000_0000;
            unique case (s_axi_araddr_i)
                `TCSP_OFS_CTRL: rdata_d[1:0] = mode_q;
                `TCSP_OFS_STATUS: rdata_d[9:0] = {recov_sel_s, ext_oc, grant_s,
                    attach_i, adv_i, supply_en_q, fault_oe_q, src_state_q};
                `TCSP_OFS_IRQ_STAT: rdata_d[3:0] = irq_stat_q;
                `TCSP_OFS_IRQ_MASK: rdata_d[3:0] = irq_mask_q;
                default: rresp_d = `TCSP_RESP_DECERR;
            endcase
        end
        awready_d = !aw_full_d && !bvalid_d;
        wready_d = !w_full_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `TCSP_RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `TCSP_RESP_OKAY;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            arready_q <= 1'b0;
            mode_q <= tcsp_mode_type'(`TCSP_CTRL_RST);
            irq_mask_q <= tcsp_irq_type'(`TCSP_MASK_RST);
            irq_stat_q <= '0;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            aw_addr_q <= aw_addr_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            arready_q <= arready_d;
            mode_q <= mode_d;
            irq_mask_q <= irq_mask_d;
            irq_stat_q <= irq_stat_d;
        end
    end

    assign s_axi_awready_o = awready_q;
    assign s_axi_wready_o = wready_q;
    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o = bresp_q;
    assign s_axi_arready_o = arready_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rdata_o = rdata_q;
    assign s_axi_rresp_o = rresp_q;

endmodule // tcsp_port_signals

`default_nettype wire

/* test/tcsp_port_signals_sva.sv */
// Purpose: Port-level checks of the standalone port signal block
// Assumes: One clock, synchronous active-high reset
// Notes: Sees top-level ports only
`timescale 1ns/1ps
`default_nettype none
module tcsp_port_signals_sva (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic host_port_power_grant_i,
    input wire logic overcurrent_fault_in_n_i,
    input wire logic vconn_overcurrent_i,
    input wire logic port_supply_en_o,
    input wire logic fault_report_out_o,
    input wire logic fault_report_out_oe_o,
    input wire tcsp_pkg::tcsp_sink_ind_type sink_ind_o,
    input wire tcsp_pkg::tcsp_sink_ind_type sink_ind_oe_o,
    input wire logic irq_n_o
);
    import tcsp_pkg::*;
    logic [3:0] oc_age_q, oc_age_d;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    // ==========================================================
    // Age of last overcurrent; saturates so long idle never wraps
    always_comb begin
        oc_age_d = (oc_age_q == 4'hf) ? oc_age_q : oc_age_q + 4'h1;
        if (!overcurrent_fault_in_n_i || vconn_overcurrent_i) begin
            oc_age_d = 4'h0;
        end
    end
    always_ff @(posedge core_clk_i) begin
        oc_age_q <= srst_i ? 4'hf : oc_age_d;
    end
    // ==========================================================
    // Pin relations
    chk_sink_onehot: assert property ($onehot0(sink_ind_oe_o))
        else $error("more than one sink pin pulled low");
    chk_od_data_low: assert property (sink_ind_o == 3'h0 &&
        !fault_report_out_o && !irq_n_o)
        else $error("open-drain data not low");
    chk_sink_vs_src: assert property (|sink_ind_oe_o |->
        !port_supply_en_o && !fault_report_out_oe_o)
        else $error("sink pin active with source outputs");
    chk_fault_supply: assert property (fault_report_out_oe_o [*3] |->
        !port_supply_en_o)
        else $error("supply on during fault");
    chk_grant_gate: assert property (!host_port_power_grant_i [*5] |-> !port_supply_en_o)
        else $error("supply on without grant");
    chk_oc_gate: assert property (!overcurrent_fault_in_n_i [*5] |-> !port_supply_en_o)
        else $error("supply on during overcurrent");
    chk_fault_cause: assert property ($rose(fault_report_out_oe_o) |->
        oc_age_q < 4'h8)
        else $error("fault report without overcurrent");
    // Bus answers
    chk_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write answer dropped early");
    chk_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |->
        ##[1:2] s_axi_rvalid_o)
        else $error("read answer late");
    cover property ($rose(port_supply_en_o));
    cover property ($rose(fault_report_out_oe_o));
    cover property (sink_ind_oe_o.high);
endmodule // tcsp_port_signals_sva
`default_nettype wire

/* test/tcsp_supply_partner.sv */
// Purpose: External supply switch and host hub port control
// Assumes: Bench commands grant and overcurrent
// Notes: Fault lines carry pull-ups when released
`timescale 1ns/1ps
`default_nettype none
module tcsp_supply_partner (
    input wire logic core_clk_i,
    input wire logic grant_cmd_i,
    input wire logic oc_cmd_i,
    input wire logic port_supply_en_i,
    input wire logic fault_oe_i,
    output logic host_port_power_grant_o,
    output logic overcurrent_fault_in_n_o,
    output logic vbus_on_o,
    output logic fault_line_o
);
    // Hub port power pin is a registered GPIO, so it lags the command
    always_ff @(posedge core_clk_i) begin
        host_port_power_grant_o <= grant_cmd_i;
    end
    // Switch pulls its fault line low; pull-up otherwise
    assign overcurrent_fault_in_n_o = !oc_cmd_i;
    // VBUS present only while enabled and not tripped
    assign vbus_on_o = port_supply_en_i && !oc_cmd_i;
    // Hub fault input with pull-up
    assign fault_line_o = !fault_oe_i;
endmodule // tcsp_supply_partner
`default_nettype wire

/* test/tcsp_port_signals_tb_top.sv */
// Purpose: Self-checking bench of the standalone port signal block
// Assumes: Recovery delay shortened to 8 cycles
// Notes: Random attach and advertisement with fixed seed
`timescale 1ns/1ps
`include "tcsp_consts.svh"
`default_nettype none
module tcsp_port_signals_tb_top;
    import tcsp_pkg::*;
    logic core_clk_i, srst_i = 1'b1;
    logic [3:0] s_axi_awaddr_i = 4'h0, s_axi_araddr_i = 4'h0, s_axi_wstrb_i = 4'h0;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
    logic [31:0] s_axi_wdata_i = 32'h0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic [31:0] s_axi_rdata_o;
    logic attach_i = 1'b0, vconn_overcurrent_i = 1'b0, fault_recovery_sel_i = 1'b0;
    tcsp_adv_type adv_i = TCSP_ADV_NONE;
    logic grant_cmd = 1'b0, oc_cmd = 1'b0, vbus_on, fault_line;
    logic host_port_power_grant_i, overcurrent_fault_in_n_i;
    logic port_supply_en_o, fault_report_out_o, fault_report_out_oe_o, irq_n_o, irq_n_oe_o;
    tcsp_sink_ind_type sink_ind_o, sink_ind_oe_o;
    int failures = 0, total_checks = 0;
    tcsp_port_signals #(.RECOVER_CYCLES(8)) tcsp_port_signals_inst (
        .core_clk_i(core_clk_i), .srst_i(srst_i),
        .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
        .s_axi_awready_o(s_axi_awready_o), .s_axi_wdata_i(s_axi_wdata_i),
        .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
        .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
        .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
        .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
        .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
        .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
        .s_axi_rready_i(s_axi_rready_i), .attach_i(attach_i), .adv_i(adv_i),
        .vconn_overcurrent_i(vconn_overcurrent_i),
        .host_port_power_grant_i(host_port_power_grant_i),
        .overcurrent_fault_in_n_i(overcurrent_fault_in_n_i),
        .fault_recovery_sel_i(fault_recovery_sel_i), .port_supply_en_o(port_supply_en_o),
        .fault_report_out_o(fault_report_out_o), .fault_report_out_oe_o(fault_report_out_oe_o),
        .sink_ind_o(sink_ind_o), .sink_ind_oe_o(sink_ind_oe_o),
        .irq_n_o(irq_n_o), .irq_n_oe_o(irq_n_oe_o));
    tcsp_supply_partner tcsp_supply_partner_inst (
        .core_clk_i(core_clk_i), .grant_cmd_i(grant_cmd), .oc_cmd_i(oc_cmd),
        .port_supply_en_i(port_supply_en_o), .fault_oe_i(fault_report_out_oe_o),
        .host_port_power_grant_o(host_port_power_grant_i),
        .overcurrent_fault_in_n_o(overcurrent_fault_in_n_i),
        .vbus_on_o(vbus_on), .fault_line_o(fault_line));
    // ==========================================================
    // Helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Valids drop once taken; bready may wait for bvalid; bounded wait
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        @(posedge core_clk_i);
        s_axi_awaddr_i <= a;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wdata_i <= d;
        s_axi_wstrb_i <= 4'hf;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'($urandom_range(1));
        do begin
            @(posedge core_clk_i);
            s_axi_awvalid_i <= s_axi_awvalid_i && !s_axi_awready_o;
            s_axi_wvalid_i <= s_axi_wvalid_i && !s_axi_wready_o;
            if (s_axi_bvalid_o && !s_axi_bready_i) s_axi_bready_i <= 1'b1;
            n++;
        end while (!(s_axi_bvalid_o && s_axi_bready_i) && n < 100);
        s_axi_bready_i <= 1'b0;
        check({s_axi_bvalid_o, s_axi_bresp_o}, {1'b1, er});
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                          input logic [1:0] er);
        int n = 0;
        @(posedge core_clk_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        do begin
            @(posedge core_clk_i);
            s_axi_arvalid_i <= s_axi_arvalid_i && !s_axi_arready_o;
            n++;
        end while (s_axi_rvalid_o !== 1'b1 && n < 100);
        s_axi_rready_i <= 1'b0;
        check(s_axi_rdata_o & m, e);
        check({s_axi_rvalid_o, s_axi_rresp_o}, {1'b1, er});
    endtask
    // One sink pin per advertisement, only in sink mode with attach
    function automatic tcsp_sink_ind_type sink_exp(input logic a, input tcsp_adv_type v);
        sink_exp = '0;
        sink_exp.dflt = a && v == TCSP_ADV_DEFAULT;
        sink_exp.mid = a && v == TCSP_ADV_1A5;
        sink_exp.high = a && v == TCSP_ADV_3A0;
    endfunction
    // ==========================================================
    // Clock and watchdog
    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    initial begin
        repeat (8000) @(posedge core_clk_i);
        failures++;
        complete_run();
    end
    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'h0db16b77));
        repeat (20) @(posedge core_clk_i);
        srst_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        rd_chk(`TCSP_OFS_CTRL, 32'h3, `TCSP_CTRL_RST, `TCSP_RESP_OKAY);
        rd_chk(`TCSP_OFS_IRQ_MASK, 32'hf, `TCSP_MASK_RST, `TCSP_RESP_OKAY);
        rd_chk(4'h6, 32'hffffffff, 32'h0, `TCSP_RESP_DECERR);
        axi_wr(4'h6, 32'h1, `TCSP_RESP_DECERR);
        // Sink: every advertisement first, then random traffic
        axi_wr(`TCSP_OFS_CTRL, 32'h2, `TCSP_RESP_OKAY);
        for (int i = 0; i < 24; i++) begin
            @(posedge core_clk_i);
            attach_i <= (i < 4) || ($urandom_range(3) != 0);
            adv_i <= (i < 4) ? tcsp_adv_type'(i) : tcsp_adv_type'($urandom_range(3));
            repeat (3) @(posedge core_clk_i);
            check(sink_ind_oe_o, sink_exp(attach_i, adv_i));
        end
        axi_wr(`TCSP_OFS_CTRL, 32'h3, `TCSP_RESP_OKAY);
        repeat (3) @(posedge core_clk_i);
        check({sink_ind_oe_o, port_supply_en_o}, 32'h0);
        // Source: grant gates supply
        attach_i <= 1'b1;
        axi_wr(`TCSP_OFS_CTRL, 32'h1, `TCSP_RESP_OKAY);
        repeat (10) @(posedge core_clk_i);
        check(port_supply_en_o, 32'h0);
        grant_cmd <= 1'b1;
        repeat (8) @(posedge core_clk_i);
        check({vbus_on, port_supply_en_o, fault_report_out_oe_o}, 32'h6);
        rd_chk(`TCSP_OFS_STATUS, 32'h3cf, 32'hc9, `TCSP_RESP_OKAY);
        // Overcurrent with strap low stays faulted
        oc_cmd <= 1'b1;
        repeat (8) @(posedge core_clk_i);
        check({port_supply_en_o, fault_line}, 32'h0);
        oc_cmd <= 1'b0;
        repeat (40) @(posedge core_clk_i);
        check({port_supply_en_o, fault_report_out_oe_o}, 32'h1);
        rd_chk(`TCSP_OFS_IRQ_STAT, 32'h1, 32'h1, `TCSP_RESP_OKAY);
        check(irq_n_oe_o, 32'h0);
        axi_wr(`TCSP_OFS_IRQ_MASK, 32'h1, `TCSP_RESP_OKAY);
        repeat (2) @(posedge core_clk_i);
        check(irq_n_oe_o, 32'h1);
        axi_wr(`TCSP_OFS_IRQ_STAT, 32'h1, `TCSP_RESP_OKAY);
        repeat (2) @(posedge core_clk_i);
        check(irq_n_oe_o, 32'h0);
        axi_wr(`TCSP_OFS_CTRL, 32'h0, `TCSP_RESP_OKAY);
        repeat (3) @(posedge core_clk_i);
        check(fault_report_out_oe_o, 32'h0);
        // Strap high: VCONN then external fault, each recovers
        fault_recovery_sel_i <= 1'b1;
        axi_wr(`TCSP_OFS_CTRL, 32'h1, `TCSP_RESP_OKAY);
        repeat (10) @(posedge core_clk_i);
        vconn_overcurrent_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        vconn_overcurrent_i <= 1'b0;
        check({port_supply_en_o, fault_report_out_oe_o}, 32'h1);
        repeat (30) @(posedge core_clk_i);
        check({port_supply_en_o, fault_report_out_oe_o}, 32'h2);
        oc_cmd <= 1'b1;
        repeat (6) @(posedge core_clk_i);
        oc_cmd <= 1'b0;
        repeat (40) @(posedge core_clk_i);
        check(vbus_on, 32'h1);
        grant_cmd <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        check(port_supply_en_o, 32'h0);
        complete_run();
    end
endmodule // tcsp_port_signals_tb_top
bind tcsp_port_signals tcsp_port_signals_sva tcsp_port_signals_sva_inst (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
    .s_axi_bresp_o(s_axi_bresp_o), .host_port_power_grant_i(host_port_power_grant_i),
    .overcurrent_fault_in_n_i(overcurrent_fault_in_n_i),
    .vconn_overcurrent_i(vconn_overcurrent_i), .port_supply_en_o(port_supply_en_o),
    .fault_report_out_o(fault_report_out_o), .fault_report_out_oe_o(fault_report_out_oe_o),
    .sink_ind_o(sink_ind_o), .sink_ind_oe_o(sink_ind_oe_o), .irq_n_o(irq_n_o));
`default_nettype wire
